// ===== hw/mms_pkg.sv
// Constants and types for the measurement mode scheduler.
// Assumes a 100 MHz system clock; all intervals except the rate 3 gap, which GAP3_CYC sets, are derived from it.
package mms_pkg;

    // ==========================================================
    // Clock and time base
    // ==========================================================
    localparam int CLK_HZ          = 100000000;
    localparam int OSC_HZ          = 1850000;
    localparam int US_CYC          = CLK_HZ / 1000000;

    // Fixed overheads in microseconds.
    localparam int WAKE_US         = 100;
    localparam int CAP_CALC_US     = 300;
    localparam int TEMP_CALC_US    = 250;
    localparam int WORST_NUM       = 11;
    localparam int WORST_DEN       = 10;

    // Conversion times per resolution code in microseconds.
    localparam int CONV8_US        = 300;
    localparam int CONV10_US       = 1150;
    localparam int CONV12_US       = 4500;
    localparam int CONV14_US       = 18000;

    // Power-down gaps per rate code in milliseconds.
    localparam int GAP0_MS         = 0;
    localparam int GAP1_MS         = 5;
    localparam int GAP2_MS         = 25;
    localparam int GAP3_MS         = 125;

    // ==========================================================
    // Scheduling constants
    // ==========================================================
    localparam int TEMP_EVERY      = 6;
    localparam logic [2:0] CAP_CNT_RST = 3'h0;

    // Status codes carried with fetched data.
    localparam logic [1:0] ST_VALID = 2'h0;
    localparam logic [1:0] ST_STALE = 2'h1;
    localparam logic [1:0] ST_CMD   = 2'h2;

    // Configuration field positions in the stored word.
    localparam int CFG_MODE_BIT    = 0;
    localparam int CFG_RATE_LSB    = 1;
    localparam int CFG_RES_LSB     = 3;
    localparam logic [15:0] CFG_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WAKE   = 3'b001,
        ST_TCONV  = 3'b010,
        ST_CCONV  = 3'b011,
        ST_UPDATE = 3'b100,
        ST_GAP    = 3'b101
    } mms_state_type;

endpackage

// ===== hw/mms_scheduler.sv
// Measurement cycle scheduler for a capacitive sensor conditioner.
// Assumes the serial front end decodes commands into one-cycle pulses
// and converter results arrive as ready-made words at the end of a step.
//
// Notes on behaviour
// - One stored bit picks periodic or on-demand sleep measurement mode.
// - Periodic gap by rate code: 0, 5, 25 or 125 ms.
// - Rate code zero skips the gap and measures back to back.
// - Output register and modulated and alarm outputs update before the gap.
// - Gap expiry starts the next cycle with no command.
// - Sleep mode never starts a measurement without a host command.
// - Periodic mode converts temperature once per six capacitance cycles.
// - Capacitance conversion follows the temperature step at once.
// - Capacitance cycle is conversion plus 0.1 ms and 0.3 ms overheads.
// - Temperature step is conversion plus 0.25 ms calculation.
// - Temperature spacing is six capacitance spacings plus temperature step.
// - Capacitance spacing spans 0.70 ms up to 143.40 ms.
// - Durations scale with oscillator; worst case is typical times 1.1, except the rate 3 gap, which is set by GAP3_CYC alone.
// - Periodic mode drives serial, both modulated and alarm outputs.
// - Fetch command returns the output register contents.
// - Fetch status tells fresh valid data from stale data.
// - Refetch before a new cycle returns same data with stale status.
// - Ready rises when valid unfetched data sits in the output register.
// - Status 00 fresh, 01 fetched, 10 command mode, 11 unused.
// - Resolution code picks 8 to 14 bits, 0.30 to 18.0 ms.
// - All intervals except the rate 3 gap, which GAP3_CYC sets, come from the 1.85 MHz internal time base; here they count system clock cycles via CYC_PER_US.
// - Sleep mode converts only on request, powered down otherwise.
`timescale 1ns/1ps

module mms_scheduler #(
    parameter int DATA_W     = 14,
    parameter int WORST      = 0,
    parameter int GAP3_CYC   = 12500000,
    parameter int CYC_PER_US = mms_pkg::US_CYC
) (
    input  wire logic              clock,         // 100 MHz clock
    input  wire logic              rst_b,         // sync reset, active low
    input  wire logic              start,         // normal operation begins
    input  wire logic              command_mode,  // device in command mode
    input  wire logic [15:0]       maker_config_word, // stored config
    input  wire logic              conversion_request_command, // pulse
    input  wire logic              result_fetch_command,       // pulse
    input  wire logic [DATA_W-1:0] cap_result,    // corrected capacitance
    input  wire logic [DATA_W-1:0] temp_result,   // corrected temperature
    output logic [DATA_W-1:0]      fetch_cap,     // fetched capacitance
    output logic [DATA_W-1:0]      fetch_temp,    // fetched temperature
    output logic [1:0]             fetch_status,  // fetch status bits
    output logic                   fetch_valid,   // fetch answer strobe
    output logic                   ready,         // unfetched data present
    output logic [DATA_W-1:0]      capacitance_modulated_out, // level
    output logic [DATA_W-1:0]      temperature_modulated_out, // level
    output logic [DATA_W-1:0]      alarm_value,   // value for alarms
    output logic                   powered_down,  // core is powered down
    output logic                   temp_pulse,    // temperature step done
    output logic                   cap_pulse      // capacitance step done
);

    // ==========================================================
    // Elaboration checks and cycle counts
    // ==========================================================
    initial begin
        if (DATA_W < 8 || DATA_W > 16) begin
            $error("DATA_W must lie between 8 and 16");
        end
        if (GAP3_CYC < 1) begin
            $error("GAP3_CYC must be at least one");
        end
        // The 25 ms gap, the longest one computed here, still fits the 32-bit step counter far above this.
        if (CYC_PER_US < 1 || CYC_PER_US > 10000) begin
            $error("CYC_PER_US must lie between 1 and 10000");
        end
    end

    localparam int SCL_N = (WORST != 0) ? mms_pkg::WORST_NUM : 1;
    localparam int SCL_D = (WORST != 0) ? mms_pkg::WORST_DEN : 1;
    // Typical times follow the 1.85 MHz internal time base and are kept
    // here as system clock cycles per microsecond. A test may shrink the
    // ratio to keep runs short; the order of the steps does not change.
    localparam int UC = CYC_PER_US;

    function automatic logic [31:0] cyc(input int us);
        cyc = 32'((longint'(us) * UC * SCL_N) / SCL_D);
    endfunction

    localparam logic [31:0] WAKE_C  = cyc(mms_pkg::WAKE_US);
    localparam logic [31:0] CCALC_C = cyc(mms_pkg::CAP_CALC_US);
    localparam logic [31:0] TCALC_C = cyc(mms_pkg::TEMP_CALC_US);
    localparam logic [31:0] CONV0_C = cyc(mms_pkg::CONV8_US);
    localparam logic [31:0] CONV1_C = cyc(mms_pkg::CONV10_US);
    localparam logic [31:0] CONV2_C = cyc(mms_pkg::CONV12_US);
    localparam logic [31:0] CONV3_C = cyc(mms_pkg::CONV14_US);
    localparam logic [31:0] GAP1_C  = cyc(mms_pkg::GAP1_MS * 1000);
    localparam logic [31:0] GAP2_C  = cyc(mms_pkg::GAP2_MS * 1000);
    localparam logic [31:0] GAP3_C  = 32'(GAP3_CYC);

    // ==========================================================
    // Latched configuration
    // ==========================================================
    logic        run_ff;
    logic        sleep_ff;
    logic [1:0]  rate_ff;
    logic [1:0]  res_ff;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            run_ff   <= 1'b0;
            sleep_ff <= 1'b0;
            rate_ff  <= 2'h0;
            res_ff   <= 2'h0;
        end else if (start && !run_ff) begin
            run_ff   <= 1'b1;
            sleep_ff <= maker_config_word[mms_pkg::CFG_MODE_BIT];
            rate_ff  <= maker_config_word[mms_pkg::CFG_RATE_LSB +: 2];
            res_ff   <= maker_config_word[mms_pkg::CFG_RES_LSB +: 2];
        end
    end

    // Conversion time by resolution, same for both quantities.
    wire [31:0] conv_c = (res_ff == 2'h0) ? CONV0_C :
                         (res_ff == 2'h1) ? CONV1_C :
                         (res_ff == 2'h2) ? CONV2_C : CONV3_C;
    wire [31:0] gap_c  = (rate_ff == 2'h1) ? GAP1_C :
                         (rate_ff == 2'h2) ? GAP2_C : GAP3_C;
    wire        no_gap = (rate_ff == 2'h0);

    // ==========================================================
    // Sequencer
    // ==========================================================
    mms_pkg::mms_state_type state_ff;
    mms_pkg::mms_state_type nxt_state;
    logic [31:0] cnt_ff;
    logic [2:0]  capn_ff;
    logic        first_ff;
    logic        pend_ff;

    wire cnt_done = (cnt_ff == 32'h0);
    // Every sleep cycle and the very first cycle include temperature.
    // The count reaches six once six capacitance results follow the last
    // temperature step, so temperature comes once per six of them.
    wire need_temp = sleep_ff || first_ff ||
                     (capn_ff == 3'(mms_pkg::TEMP_EVERY));
    wire go_req = sleep_ff && (conversion_request_command || pend_ff);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mms_pkg::ST_IDLE: begin
                if (run_ff && (!sleep_ff || go_req)) begin
                    nxt_state = mms_pkg::ST_WAKE;
                end
            end
            mms_pkg::ST_WAKE: begin
                if (cnt_done) begin
                    nxt_state = need_temp ? mms_pkg::ST_TCONV
                                          : mms_pkg::ST_CCONV;
                end
            end
            mms_pkg::ST_TCONV: begin
                if (cnt_done) begin
                    nxt_state = mms_pkg::ST_CCONV;
                end
            end
            mms_pkg::ST_CCONV: begin
                if (cnt_done) begin
                    nxt_state = mms_pkg::ST_UPDATE;
                end
            end
            mms_pkg::ST_UPDATE: begin
                if (sleep_ff) begin
                    nxt_state = mms_pkg::ST_IDLE;
                end else if (no_gap) begin
                    nxt_state = mms_pkg::ST_WAKE;
                end else begin
                    nxt_state = mms_pkg::ST_GAP;
                end
            end
            mms_pkg::ST_GAP: begin
                if (cnt_done) begin
                    nxt_state = mms_pkg::ST_WAKE;
                end
            end
            default: nxt_state = mms_pkg::ST_IDLE;
        endcase
    end

    // Load value for the step counter on entry to each timed state.
    wire        enter = (nxt_state != state_ff) ||
                        (state_ff == mms_pkg::ST_UPDATE);
    wire [31:0] load_c =
        (nxt_state == mms_pkg::ST_WAKE)  ? WAKE_C - 32'h1 :
        (nxt_state == mms_pkg::ST_TCONV) ? conv_c + TCALC_C - 32'h1 :
        (nxt_state == mms_pkg::ST_CCONV) ? conv_c + CCALC_C - 32'h1 :
        (nxt_state == mms_pkg::ST_GAP)   ? gap_c - 32'h1 : 32'h0;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_ff <= mms_pkg::ST_IDLE;
            cnt_ff   <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= enter ? load_c : (cnt_done ? 32'h0 : cnt_ff - 32'h1);
        end
    end

    // Capacitance cycle counter and pending request.
    wire t_end = (state_ff == mms_pkg::ST_TCONV) && cnt_done;
    wire c_end = (state_ff == mms_pkg::ST_CCONV) && cnt_done;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            capn_ff  <= mms_pkg::CAP_CNT_RST;
            first_ff <= 1'b1;
            pend_ff  <= 1'b0;
        end else begin
            if (t_end) begin
                capn_ff <= mms_pkg::CAP_CNT_RST;
            end else if (c_end) begin
                capn_ff <= capn_ff + 3'h1;
            end
            if (c_end) begin
                first_ff <= 1'b0;
            end
            // A request arriving mid-cycle is held for the next one.
            if (conversion_request_command && sleep_ff &&
                state_ff != mms_pkg::ST_IDLE) begin
                pend_ff <= 1'b1;
            end else if (state_ff == mms_pkg::ST_IDLE && go_req) begin
                pend_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Output register, fetch and ready
    // ==========================================================
    logic [DATA_W-1:0] treg_ff;
    logic [DATA_W-1:0] creg_ff;
    logic              fresh_ff;
    logic              done_ff;
    logic              fv_ff;
    logic [1:0]        fst_ff;

    wire upd = (state_ff == mms_pkg::ST_UPDATE);
    wire [1:0] st_now = command_mode ? mms_pkg::ST_CMD :
                        fresh_ff ? mms_pkg::ST_VALID
                                 : mms_pkg::ST_STALE;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            treg_ff   <= '0;
            creg_ff   <= '0;
            fresh_ff  <= 1'b0;
            done_ff   <= 1'b0;
            fv_ff     <= 1'b0;
            fst_ff    <= mms_pkg::ST_STALE;
            fetch_cap <= '0;
            fetch_temp <= '0;
            capacitance_modulated_out <= '0;
            temperature_modulated_out <= '0;
            alarm_value <= '0;
        end else begin
            if (t_end) begin
                treg_ff <= temp_result;
            end
            if (c_end) begin
                creg_ff <= cap_result;
            end
            if (upd) begin
                // Outputs refresh before the gap begins.
                done_ff <= 1'b1;
                capacitance_modulated_out <= creg_ff;
                temperature_modulated_out <= treg_ff;
                alarm_value <= creg_ff;
            end
            // A new cycle landing with a fetch wins: data stays fresh.
            if (upd) begin
                fresh_ff <= 1'b1;
            end else if (result_fetch_command) begin
                fresh_ff <= 1'b0;
            end
            fv_ff <= result_fetch_command;
            if (result_fetch_command) begin
                fst_ff     <= st_now;
                fetch_cap  <= done_ff ? capacitance_modulated_out
                                      : fetch_cap;
                fetch_temp <= done_ff ? temperature_modulated_out
                                      : fetch_temp;
            end
        end
    end

    assign fetch_status = fst_ff;
    assign fetch_valid  = fv_ff;
    assign ready        = fresh_ff;
    assign powered_down = (state_ff == mms_pkg::ST_IDLE) ||
                          (state_ff == mms_pkg::ST_GAP);
    assign temp_pulse   = t_end;
    assign cap_pulse    = c_end;

endmodule

// ===== verification/mms_host_model.sv
// Host controller model: sends fetch and measurement request pulses.
// Assumes the scheduler samples both commands on the rising clock edge.
`timescale 1ns/1ps

module mms_host_model (
    input  wire logic clock,                      // system clock
    input  wire logic ready,                      // fresh data flag
    output logic      result_fetch_command,       // fetch pulse
    output logic      conversion_request_command  // request pulse
);
    initial begin
        result_fetch_command       = 1'b0;
        conversion_request_command = 1'b0;
    end

    // ============================================================
    // Host requests
    // ============================================================
    // Pulses change on the falling edge so the sampling edge sees them.
    task automatic pulse_fetch();
        @(negedge clock);
        result_fetch_command = 1'b1;
        @(negedge clock);
        result_fetch_command = 1'b0;
    endtask

    task automatic pulse_request();
        @(negedge clock);
        conversion_request_command = 1'b1;
        @(negedge clock);
        conversion_request_command = 1'b0;
    endtask

    // Watching ready spares the noise that repeated polling would cause.
    task automatic wait_ready(input int lim, output bit seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge clock);
            seen = (ready === 1'b1);
        end
    endtask
endmodule

// ===== verification/mms_scheduler_assertions.sv
// Checker for the measurement mode scheduler, bound to its ports.
// Assumes the stored config word is held steady while the block runs.
`timescale 1ns/1ps

module mms_scheduler_assertions #(
    parameter int DATA_W = 14
) (
    input wire logic              clock,                      // clock
    input wire logic              rst_b,                      // reset
    input wire logic              start,                      // run
    input wire logic              command_mode,               // cmd mode
    input wire logic [15:0]       maker_config_word,          // config
    input wire logic              conversion_request_command, // request
    input wire logic              result_fetch_command,       // fetch
    input wire logic [DATA_W-1:0] cap_result,                 // cap word
    input wire logic [1:0]        fetch_status,               // status
    input wire logic              fetch_valid,                // answer
    input wire logic              ready,                      // fresh
    input wire logic [DATA_W-1:0] capacitance_modulated_out,  // level
    input wire logic              powered_down,               // idle
    input wire logic              temp_pulse,                 // t done
    input wire logic              cap_pulse                   // c done
);
    logic [2:0] caps_ff;
    logic       seen_ff;

    always_ff @(posedge clock) begin
        if (!rst_b || temp_pulse) begin
            caps_ff <= 3'h0;
        end else if (cap_pulse && caps_ff != 3'h7) begin
            caps_ff <= caps_ff + 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        seen_ff <= rst_b && (seen_ff || temp_pulse);
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ============================================================
    // Properties
    // ============================================================
    a_fetch_answer: assert property (
        result_fetch_command |=> fetch_valid) else $error("no answer");
    a_stale_refetch: assert property (
        result_fetch_command && !ready && !command_mode
        |=> fetch_status == mms_pkg::ST_STALE) else $error("not stale");
    a_fresh_status: assert property (
        result_fetch_command && ready && !command_mode
        |=> fetch_status == mms_pkg::ST_VALID) else $error("not valid");
    a_ready_clears: assert property (
        result_fetch_command && ready && !$past(cap_pulse)
        |=> !ready) else $error("ready kept after fetch");
    a_ready_rises: assert property (
        cap_pulse |-> ##2 ready) else $error("ready not raised");
    a_outputs_update: assert property (
        cap_pulse |-> ##2 capacitance_modulated_out == $past(cap_result, 2))
        else $error("output not updated");
    a_sleep_idle: assert property (
        maker_config_word[0] && powered_down && !start && !$past(start)
        && !conversion_request_command
        && !$past(conversion_request_command) |=> powered_down)
        else $error("sleep woke alone");
    a_no_gap: assert property (
        !maker_config_word[0] && maker_config_word[2:1] == 2'h0
        && cap_pulse |=> !powered_down [*4]) else $error("gap at rate 0");
    a_temp_count: assert property (
        temp_pulse && seen_ff && !maker_config_word[0] |-> caps_ff == 3'h6)
        else $error("temperature count wrong");

    c_fetch_fresh: cover property (result_fetch_command && ready);
    c_temp_step: cover property (temp_pulse && seen_ff);
    c_sleep_req: cover property (conversion_request_command);
endmodule

bind mms_scheduler mms_scheduler_assertions #(.DATA_W(DATA_W)) u_chk (
    .clock(clock), .rst_b(rst_b), .start(start),
    .command_mode(command_mode), .maker_config_word(maker_config_word),
    .conversion_request_command(conversion_request_command),
    .result_fetch_command(result_fetch_command), .cap_result(cap_result),
    .fetch_status(fetch_status), .fetch_valid(fetch_valid), .ready(ready),
    .capacitance_modulated_out(capacitance_modulated_out),
    .powered_down(powered_down), .temp_pulse(temp_pulse),
    .cap_pulse(cap_pulse)
);

// ===== verification/mms_scheduler_tb_top.sv
// Testbench for the measurement scheduler in both measurement modes.
// Runs the time base at one cycle per microsecond to keep the run short.
`timescale 1ns/1ps

module mms_scheduler_tb_top;
    logic        clock, rst_b, start, command_mode, fetch_valid, ready;
    logic        powered_down, temp_pulse, cap_pulse, fetch_cmd, req_cmd;
    logic [15:0] maker_config_word;
    logic [1:0]  fetch_status;
    logic [13:0] cap_result, temp_result, fetch_cap, fetch_temp;
    logic [13:0] cap_mod, temp_mod;
    int          miscompares, tests_run, cyc, t0;
    int          cap_q[$];
    int          tmp_q[$];

    localparam int GAP3    = 2000;
    localparam int TSTEP   = mms_pkg::CONV8_US + mms_pkg::TEMP_CALC_US;
    localparam int CSTEP   = mms_pkg::WAKE_US + mms_pkg::CONV8_US +
                             mms_pkg::CAP_CALC_US;
    localparam int CSTEP10 = mms_pkg::WAKE_US + mms_pkg::CONV10_US +
                             mms_pkg::CAP_CALC_US;

    mms_scheduler #(.DATA_W(14), .WORST(0), .GAP3_CYC(GAP3),
                    .CYC_PER_US(1)) u_dut (
        .clock(clock), .rst_b(rst_b), .start(start),
        .command_mode(command_mode), .maker_config_word(maker_config_word),
        .conversion_request_command(req_cmd),
        .result_fetch_command(fetch_cmd), .cap_result(cap_result),
        .temp_result(temp_result), .fetch_cap(fetch_cap),
        .fetch_temp(fetch_temp), .fetch_status(fetch_status),
        .fetch_valid(fetch_valid), .ready(ready),
        .capacitance_modulated_out(cap_mod),
        .temperature_modulated_out(temp_mod), .alarm_value(),
        .powered_down(powered_down), .temp_pulse(temp_pulse),
        .cap_pulse(cap_pulse));

    mms_host_model u_host (.clock(clock), .ready(ready),
        .result_fetch_command(fetch_cmd), .conversion_request_command(req_cmd));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // The step pulses are combinational, so they are sampled mid-cycle.
    always @(negedge clock) begin
        cyc = cyc + 1;
        if (cap_pulse === 1'b1) cap_q.push_back(cyc);
        if (temp_pulse === 1'b1) tmp_q.push_back(cyc);
        if (cyc == 40000) begin
            miscompares++;
            end_sim();
        end
    end

    // ============================================================
    // Tasks
    // ============================================================
    task automatic chk(input bit ok, input string msg);
        tests_run++;
        if (!ok) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic near(input int got, input int exp, input string msg);
        chk(got >= exp - 10 && got <= exp + 10, msg);
    endtask

    task automatic do_reset(input logic [15:0] cw);
        maker_config_word = cw;
        rst_b = 1'b0;
        repeat (10) @(negedge clock);
        rst_b = 1'b1;
        @(negedge clock);
        start = 1'b1;
        t0 = cyc;
        cap_q.delete();
        tmp_q.delete();
        @(negedge clock);
        start = 1'b0;
    endtask

    task automatic wait_caps(input int n);
        for (int i = 0; i < 8000 && cap_q.size() < n; i++) @(negedge clock);
        repeat (3) @(negedge clock);
    endtask

    task automatic fetch_chk(input logic [1:0] st, input logic [13:0] c,
                             input logic [13:0] t);
        u_host.pulse_fetch();
        chk(fetch_valid === 1'b1, "no fetch answer");
        chk(fetch_status === st, "fetch status");
        if (st !== mms_pkg::ST_CMD) begin
            chk(fetch_cap === c && fetch_temp === t, "fetch data");
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ============================================================
    // Scenarios
    // ============================================================
    initial begin
        bit seen;
        {rst_b, start, command_mode, miscompares, tests_run, cyc} = '0;
        maker_config_word = 16'h0000;
        cap_result = 14'h0a5;
        temp_result = 14'h1c3;
        do_reset(16'h0000);
        fetch_chk(mms_pkg::ST_STALE, 14'h000, 14'h000);
        u_host.wait_ready(2000, seen);
        chk(seen, "ready never rose");
        near(tmp_q[0] - t0, mms_pkg::WAKE_US + TSTEP, "temp step");
        near(cap_q[0] - t0, CSTEP + TSTEP, "first cycle time");
        fetch_chk(mms_pkg::ST_VALID, 14'h0a5, 14'h1c3);
        chk(ready === 1'b0, "ready after fetch");
        fetch_chk(mms_pkg::ST_STALE, 14'h0a5, 14'h1c3);
        command_mode = 1'b1;
        fetch_chk(mms_pkg::ST_CMD, 14'h000, 14'h000);
        command_mode = 1'b0;
        cap_result = 14'h2b6;
        temp_result = 14'h05e;
        wait_caps(2);
        near(cap_q[1] - cap_q[0], CSTEP, "cap spacing");
        chk(cap_mod === 14'h2b6 && temp_mod === 14'h1c3, "outputs");
        chk(powered_down === 1'b0, "gap at fastest rate");
        fetch_chk(mms_pkg::ST_VALID, 14'h2b6, 14'h1c3);
        wait_caps(7);
        chk(tmp_q.size() === 2, "temperature count");
        near(tmp_q[1] - tmp_q[0], 6 * CSTEP + TSTEP, "temp spacing");
        chk(temp_mod === 14'h05e, "temperature output");
        do_reset(16'h000e);
        wait_caps(1);
        chk(powered_down === 1'b1, "no gap at slow rate");
        wait_caps(2);
        near(cap_q[1] - cap_q[0], CSTEP10 + GAP3, "gap spacing");
        do_reset(16'h0001);
        repeat (2000) @(negedge clock);
        chk(cap_q.size() === 0 && powered_down === 1'b1, "sleep woke");
        u_host.pulse_request();
        repeat (3) @(negedge clock);
        chk(powered_down === 1'b0, "request ignored");
        wait_caps(1);
        chk(tmp_q.size() === 1, "sleep cycle lacks temperature");
        chk(powered_down === 1'b1, "awake after sleep cycle");
        end_sim();
    end
endmodule
